/* File: verilog/fra_pkg.sv */
// Package: opcodes, widths and reset values for the file-register ALU slice
package fra_pkg;
   localparam int unsigned DATA_W    = 8;
   localparam int unsigned FADDR_W   = 7;
   localparam logic [7:0]  W_RESET   = 8'h00;
   localparam logic        C_RESET   = 1'b0;
   localparam logic        Z_RESET   = 1'b0;
   localparam logic        FWE_RESET = 1'b0;
   localparam logic [FADDR_W-1:0] FADDR_RESET = 7'h00;
   localparam logic [DATA_W-1:0]  FDATA_RESET = 8'h00;
   localparam logic        DEST_WORK = 1'b0;
   localparam logic        DEST_FILE = 1'b1;

   typedef enum logic [2:0] {
      increment_file_op,
      or_work_with_file_op,
      shift_left_logical_op,
      shift_right_logical_op,
      move_file_op
   } fra_op_e;
endpackage

/* File: verilog/fra_result_calc.sv */
// Combinational result, carry and zero for one file-register operation
`timescale 1ns/1ns
module fra_result_calc
   import fra_pkg::*;
(
   input  wire logic [2:0]        op,        // Operation code
   input  wire logic [DATA_W-1:0] file_val,  // File operand
   input  wire logic [DATA_W-1:0] work_val,  // Working register
   output logic      [DATA_W-1:0] result,    // Result byte
   output logic                   carry_out, // New carry
   output logic                   carry_upd, // Carry is updated
   output logic                   zero_out   // New zero
);
   always_comb begin
      result    = file_val;
      carry_out = 1'b0;
      carry_upd = 1'b0;
      unique case (op)
         increment_file_op: begin
            result = file_val + 8'h01;
         end
         or_work_with_file_op: begin
            result = work_val | file_val;
         end
         shift_left_logical_op: begin
            result    = {file_val[6:0], 1'b0};
            carry_out = file_val[7];
            carry_upd = 1'b1;
         end
         shift_right_logical_op: begin
            result    = {1'b0, file_val[7:1]};
            carry_out = file_val[0];
            carry_upd = 1'b1;
         end
         move_file_op: begin
            result = file_val;
         end
         default: begin
            result = file_val;
         end
      endcase
   end

   assign zero_out = (result == 8'h00);
endmodule

/* File: verilog/fra_alu.sv */
// Top: file-register ALU slice with working register and C/Z flags
`timescale 1ns/1ns
module fra_alu
   import fra_pkg::*;
(
   input  wire logic               sys_clk,    // 250 MHz core clock
   input  wire logic               nrst,       // Async reset, active low
   input  wire logic               exec,       // Execute op this cycle
   input  wire logic [2:0]         op,         // Operation code (fra_op_e)
   input  wire logic               dest_sel,   // 0 to W, 1 to file
   input  wire logic [FADDR_W-1:0] file_addr,  // Addressed file register
   input  wire logic [DATA_W-1:0]  file_rdata, // File operand value
   output logic                    file_we,    // File write strobe
   output logic      [FADDR_W-1:0] file_waddr, // File write address
   output logic      [DATA_W-1:0]  file_wdata, // File write data
   output logic      [DATA_W-1:0]  work_q,     // Working register
   output logic                    carry_q,    // Carry flag
   output logic                    zero_q      // Zero flag
);
   // Decoded operation code
   fra_op_e            op_kind;

   // Destination split
   logic               to_work;
   logic               to_file;

   // Calculator outputs
   logic [DATA_W-1:0]  result;
   logic               calc_carry;
   logic               calc_zero;

   // Load enables, one per register
   logic               work_load;
   logic               file_load;
   logic               zero_load;
   logic               carry_load;

   // Next values
   logic [DATA_W-1:0]  work_d;
   logic               carry_d;
   logic               zero_d;
   logic               file_we_d;
   logic [FADDR_W-1:0] file_waddr_d;
   logic [DATA_W-1:0]  file_wdata_d;

   // Unlisted codes fold onto move: zero still
   // tracks the operand and carry stays put
   always_comb begin
      op_kind = move_file_op;
      unique case (op)
         increment_file_op: begin
            op_kind = increment_file_op;
         end
         or_work_with_file_op: begin
            op_kind = or_work_with_file_op;
         end
         shift_left_logical_op: begin
            op_kind = shift_left_logical_op;
         end
         shift_right_logical_op: begin
            op_kind = shift_right_logical_op;
         end
         move_file_op: begin
            op_kind = move_file_op;
         end
         default: begin
            op_kind = move_file_op;
         end
      endcase
   end

   // Result byte and new flags for the decoded op
   // Operand arrives in the exec cycle, unregistered
   // Carry update is decoded below, so carry_upd stays open
   fra_result_calc u_calc (
      .op        (op_kind),
      .file_val  (file_rdata),
      .work_val  (work_q),
      .result    (result),
      .carry_out (calc_carry),
      .carry_upd (),
      .zero_out  (calc_zero)
   );

   // Exactly one destination takes each executed result
   // destination select bit
   assign to_work = exec && (dest_sel == DEST_WORK);
   assign to_file = exec && (dest_sel == DEST_FILE);

   // Load enables for the decoded op
   always_comb begin
      work_load  = to_work;
      file_load  = to_file;
      // Idle cycles load nothing
      zero_load  = 1'b0;
      carry_load = 1'b0;
      if (exec) begin
         unique case (op_kind)
            increment_file_op,
            or_work_with_file_op,
            move_file_op: begin
               zero_load = 1'b1;
            end
            shift_left_logical_op,
            shift_right_logical_op: begin
               zero_load  = 1'b1;
               carry_load = 1'b1;
            end
         endcase
      end
   end

   // Working register next value
   always_comb begin
      work_d = work_q;
      if (work_load) begin
         work_d = result;
      end
   end

   always_comb begin
      zero_d = zero_q;
      if (zero_load) begin
         zero_d = calc_zero;
      end
   end

   always_comb begin
      carry_d = carry_q;
      if (carry_load) begin
         carry_d = calc_carry;
      end
   end

   // Write-back next values; address and data
   // hold their last write between strobes.
   // No forwarding: the write lands a cycle late,
   // so the caller bypasses a back-to-back read
   // of the same address.
   always_comb begin
      file_we_d    = file_load;
      file_waddr_d = file_waddr;
      file_wdata_d = file_wdata;
      if (file_load) begin
         file_waddr_d = file_addr;
         file_wdata_d = result;
      end
   end

   // W feeds the next op, so results chain back to back
   // working register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         work_q <= W_RESET;
      end else begin
         work_q <= work_d;
      end
   end

   // One-cycle strobe, low in reset so no
   // stray write follows a reset release
   // file write strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         file_we <= FWE_RESET;
      end else begin
         file_we <= file_we_d;
      end
   end

   // Address and data only meaningful with the strobe
   // write address
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         file_waddr <= FADDR_RESET;
      end else begin
         file_waddr <= file_waddr_d;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         file_wdata <= FDATA_RESET;
      end else begin
         file_wdata <= file_wdata_d;
      end
   end

   // Loaded on every executed op, so a move back
   // to the same register serves as a zero test
   // zero flag
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         zero_q <= Z_RESET;
      end else begin
         zero_q <= zero_d;
      end
   end

   // Carry resets clear; shifts are its only writers
   // carry flag
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         carry_q <= C_RESET;
      end else begin
         carry_q <= carry_d;
      end
   end
endmodule

/* File: sim/fra_alu_properties.sv */
// Checker for the file-register ALU slice
`timescale 1ns/1ns
module fra_alu_properties import fra_pkg::*; (
   input wire logic       sys_clk, nrst, exec, dest_sel, file_we, carry_q, zero_q,
   input wire logic [2:0] op,
   input wire logic [6:0] file_addr, file_waddr,
   input wire logic [7:0] file_rdata, file_wdata, work_q);
default clocking @(posedge sys_clk); endclocking
default disable iff (!nrst);
chk_inc_file: assert property (exec && op == 3'h0 && dest_sel |=>
   file_wdata == $past(file_rdata) + 8'h01) else $error("bad increment");
chk_dest_work: assert property (exec && !dest_sel |=> !file_we) else $error("bad we");
chk_dest_file: assert property (exec && dest_sel |=>
   file_we && file_waddr == $past(file_addr)) else $error("bad write");
chk_carry_kept: assert property (exec && op != 3'h2 && op != 3'h3 |=>
   $stable(carry_q)) else $error("carry moved");
chk_or_work: assert property (exec && op == 3'h1 && !dest_sel |=>
   work_q == ($past(work_q) | $past(file_rdata))) else $error("bad or");
chk_shl_carry: assert property (exec && op == 3'h2 |=>
   carry_q == $past(file_rdata[7])) else $error("bad left carry");
chk_shr_work: assert property (exec && op == 3'h3 && !dest_sel |=>
   work_q == {1'h0, $past(file_rdata[7:1])} && carry_q == $past(file_rdata[0]))
   else $error("bad right shift");
chk_move_file: assert property (exec && op == 3'h4 && dest_sel |=>
   file_wdata == $past(file_rdata)) else $error("bad move");
chk_zero_flag: assert property (exec |=>
   zero_q == (($past(dest_sel) ? file_wdata : work_q) == 8'h00)) else $error("bad zero");
chk_shl_file: assert property (exec && op == 3'h2 && dest_sel |=>
   file_wdata == {$past(file_rdata[6:0]), 1'h0}) else $error("bad left shift");
chk_idle_quiet: assert property (!exec |=> !file_we && $stable(work_q)
   && $stable(carry_q) && $stable(zero_q)) else $error("idle change");
endmodule
bind fra_alu fra_alu_properties i_chk (.*);

/* File: sim/tb_fra_alu.sv */
// Self-checking bench for the file-register ALU slice
`timescale 1ns/1ns
module tb_fra_alu;
logic       sys_clk = 1'h0, nrst = 1'h0, exec = 1'h0, dest_sel = 1'h0, file_we, carry_q, zero_q;
logic [2:0] op = 3'h0;
logic [6:0] file_addr = 7'h00, file_waddr;
logic [7:0] file_rdata = 8'h00, file_wdata, work_q;
int         n_fail = 0, total_checks = 0;
always #2 sys_clk = ~sys_clk;
fra_alu i_fra_alu (.*);
task chk(input logic ok);
   total_checks++;
   if (!ok) begin
      n_fail++;
      $display("unexpected %0t result mismatch", $time);
   end
endtask
task exe(input logic [2:0] o, input logic d, input logic [7:0] v, r, input logic c, z);
   @(posedge sys_clk);
   exec <= 1'h1;
   op <= o;
   dest_sel <= d;
   file_rdata <= v;
   file_addr <= v[6:0];
   @(posedge sys_clk);
   exec <= 1'h0;
   file_rdata <= ~v;
   #1 chk((d ? file_wdata : work_q) === r && carry_q === c && zero_q === z
      && file_we === d && (!d || file_waddr === v[6:0]));
endtask
task t_arith;
   exe(3'h0, 1'h1, 8'hFF, 8'h00, 1'h0, 1'h1);
   exe(3'h0, 1'h0, 8'h7F, 8'h80, 1'h0, 1'h0);
   exe(3'h1, 1'h0, 8'h01, 8'h81, 1'h0, 1'h0);
   exe(3'h1, 1'h1, 8'h00, 8'h81, 1'h0, 1'h0);
   $display("arith test ended");
endtask
task t_shift;
   exe(3'h2, 1'h0, 8'h81, 8'h02, 1'h1, 1'h0);
   exe(3'h2, 1'h1, 8'h40, 8'h80, 1'h0, 1'h0);
   exe(3'h3, 1'h1, 8'h01, 8'h00, 1'h1, 1'h1);
   exe(3'h3, 1'h0, 8'hFE, 8'h7F, 1'h0, 1'h0);
   $display("shift test ended");
endtask
task t_move;
   exe(3'h2, 1'h1, 8'h80, 8'h00, 1'h1, 1'h1);
   exe(3'h4, 1'h1, 8'h00, 8'h00, 1'h1, 1'h1);
   exe(3'h4, 1'h0, 8'h5A, 8'h5A, 1'h1, 1'h0);
   exe(3'h0, 1'h0, 8'h10, 8'h11, 1'h1, 1'h0);
   exe(3'h5, 1'h0, 8'h00, 8'h00, 1'h1, 1'h1);
   $display("move test ended");
endtask
task test_done;
   $display("checks %0d fails %0d", total_checks, n_fail);
   if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
   else
      $display("Errors were found");
   $finish;
endtask
initial begin
   repeat (16) @(posedge sys_clk);
   chk(work_q === 8'h00 && carry_q === 1'h0 && zero_q === 1'h0);
   nrst <= 1'h1;
   t_arith();
   t_shift();
   t_move();
   test_done();
end
endmodule
